// File: inc/sscef_pkg.sv
// package: register map, field positions, divider counts and mode decoding
package sscef_pkg;

  localparam int unsigned SSCEF_DATA_W = 8;

  localparam logic [31:0] SSCEF_ADDR_IRQ_STAT = 32'h0000_0000;
  localparam logic [31:0] SSCEF_ADDR_IRQ_MASK = 32'h0000_0004;
  localparam logic [31:0] SSCEF_ADDR_BUFFER   = 32'h0000_0008;
  localparam logic [31:0] SSCEF_ADDR_STATUS   = 32'h0000_000c;
  localparam logic [31:0] SSCEF_ADDR_CONTROL  = 32'h0000_0014;

  localparam int unsigned SSCEF_CTL_WRITE_COLLISION_FLAG_BIT = 7;
  localparam int unsigned SSCEF_CTL_OVF_BIT  = 6;
  localparam int unsigned SSCEF_CTL_EN_BIT   = 5;
  localparam int unsigned SSCEF_CTL_CKP_BIT  = 4;
  localparam logic [7:0]  SSCEF_CTL_RESET    = 8'h00;

  localparam int unsigned SSCEF_IRQ_W        = 3;
  localparam int unsigned SSCEF_IRQ_DONE_BIT = 0;
  localparam int unsigned SSCEF_IRQ_OVF_BIT  = 1;
  localparam int unsigned SSCEF_IRQ_WRITE_COLLISION_FLAG_BIT = 2;
  localparam logic [2:0]  SSCEF_IRQ_RESET    = 3'h0;

  localparam int unsigned SSCEF_STAT_FULL_BIT = 0;
  localparam int unsigned SSCEF_STAT_BUSY_BIT = 1;

  // half periods of the master serial clock, in core cycles
  localparam logic [7:0] SSCEF_HALF_DIV4   = 8'h02;
  localparam logic [7:0] SSCEF_HALF_DIV16  = 8'h08;
  localparam logic [7:0] SSCEF_HALF_DIV64  = 8'h20;
  localparam logic [7:0] SSCEF_HALF_DIVTMR = 8'h40;

  localparam logic [3:0] SSCEF_MODE_SLAVE_SS = 4'h4;
  localparam logic [3:0] SSCEF_MODE_SLAVE    = 4'h5;

  typedef enum logic [1:0] {
    SSCEF_ST_IDLE  = 2'b01,
    SSCEF_ST_SHIFT = 2'b10
  } sscef_state_e;

  function automatic logic sscef_is_master(input logic [3:0] mode);
    return mode[3:2] == 2'b00;
  endfunction

  function automatic logic sscef_is_slave(input logic [3:0] mode);
    return (mode == SSCEF_MODE_SLAVE_SS) || (mode == SSCEF_MODE_SLAVE);
  endfunction

  function automatic logic sscef_is_i2c(input logic [3:0] mode);
    return (mode == 4'h6) || (mode == 4'h7) || (mode == 4'hb) || (mode == 4'he) || (mode == 4'hf);
  endfunction

endpackage

// File: inc/sscef_eng_if.sv
// interface between register file and shift engine
`timescale 1ns/100ps
interface sscef_eng_if;
  import sscef_pkg::*;
  logic                    en;
  logic [3:0]              mode;
  logic                    clock_polarity_select;
  logic                    load;
  logic [SSCEF_DATA_W-1:0] tx_data;
  logic                    busy;
  logic                    done;
  logic [SSCEF_DATA_W-1:0] rx_data;
  logic                    i2c_xmit;

  modport ctl (output en, mode, clock_polarity_select, load, tx_data, input busy, done, rx_data, i2c_xmit);
  modport eng (input en, mode, clock_polarity_select, load, tx_data, output busy, done, rx_data, i2c_xmit);
endinterface

// File: rtl/sscef_shift_engine.sv
// serial shift engine: spi master/slave and i2c byte shifting
`timescale 1ns/100ps
module sscef_shift_engine
  import sscef_pkg::*;
#(
  parameter int unsigned DATA_W = SSCEF_DATA_W
) (
  input  wire logic  i_core_clk,
  input  wire logic  i_resetn,
  sscef_eng_if.eng   eng,
  input  wire logic  i_sck,
  input  wire logic  i_sdi,
  input  wire logic  i_ss_n,
  output logic       o_sck,
  output logic       o_sck_oe,
  output logic       o_sdo,
  output logic       o_sdo_oe
);

  sscef_state_e          state_q;
  logic [DATA_W-1:0]     sr_q;
  logic [3:0]            cnt_q;
  logic [7:0]            div_q;
  logic                  sck_q;
  logic                  sck_prev_q;
  logic                  sdo_q;
  logic                  busy_q;
  logic                  done_q;
  logic [DATA_W-1:0]     rx_q;
  logic                  xmit_q;

  wire       is_master = eng.en & sscef_is_master(eng.mode);
  wire       is_slave  = eng.en & sscef_is_slave(eng.mode);
  wire       is_i2c    = eng.en & sscef_is_i2c(eng.mode);
  wire       ss_ok     = (eng.mode != SSCEF_MODE_SLAVE_SS) | ~i_ss_n;
  wire [7:0] half      = (eng.mode[1:0] == 2'b00) ? SSCEF_HALF_DIV4 :
                         (eng.mode[1:0] == 2'b01) ? SSCEF_HALF_DIV16 :
                         (eng.mode[1:0] == 2'b10) ? SSCEF_HALF_DIV64 : SSCEF_HALF_DIVTMR;
  wire       tick      = (state_q == SSCEF_ST_SHIFT) & (div_q == half - 8'h01);
  wire       rise      = i_sck & ~sck_prev_q;
  wire       fall      = ~i_sck & sck_prev_q;
  wire       ext_lead  = (is_i2c | ~eng.clock_polarity_select) ? rise : fall;
  wire       ext_trail = (is_i2c | ~eng.clock_polarity_select) ? fall : rise;
  wire       m_lead    = is_master & tick & (sck_q == eng.clock_polarity_select);
  wire       m_trail   = is_master & tick & (sck_q != eng.clock_polarity_select);
  wire       ext_on    = (is_slave & ss_ok) | is_i2c;
  wire       lead      = m_lead | (ext_on & ext_lead);
  wire       trail     = m_trail | (ext_on & ext_trail);
  wire       last      = lead & (cnt_q == 4'(DATA_W - 1));
  wire       start     = eng.load & (is_master | is_slave | is_i2c);

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state_q <= SSCEF_ST_IDLE;
      div_q   <= 8'h00;
      sck_q   <= 1'b0;
    end else begin
      unique case (state_q)
        SSCEF_ST_IDLE: begin
          sck_q <= eng.clock_polarity_select;
          div_q <= 8'h00;
          if (start & is_master) begin
            state_q <= SSCEF_ST_SHIFT;
          end
        end
        SSCEF_ST_SHIFT: begin
          div_q <= tick ? 8'h00 : div_q + 8'h01;
          if (tick) begin
            sck_q <= ~sck_q;
          end
          if (m_trail & (cnt_q == 4'h0) | ~is_master) begin
            state_q <= SSCEF_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      sr_q       <= '0;
      cnt_q      <= 4'h0;
      sck_prev_q <= 1'b0;
      sdo_q      <= 1'b1;
      done_q     <= 1'b0;
      rx_q       <= '0;
    end else begin
      sck_prev_q <= i_sck;
      done_q     <= last;
      if (start) begin
        sr_q  <= eng.tx_data;
        sdo_q <= eng.tx_data[DATA_W-1];
      end else if (lead) begin
        sr_q  <= {sr_q[DATA_W-2:0], i_sdi};
        cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
        if (last) begin
          rx_q <= {sr_q[DATA_W-2:0], i_sdi};
        end
      end else if (trail & (cnt_q != 4'h0)) begin
        sdo_q <= sr_q[DATA_W-1];
      end
      if (!eng.en) begin
        cnt_q <= 4'h0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      busy_q   <= 1'b0;
      xmit_q   <= 1'b0;
      o_sck    <= 1'b0;
      o_sck_oe <= 1'b0;
      o_sdo    <= 1'b1;
      o_sdo_oe <= 1'b0;
    end else begin
      busy_q   <= is_master ? ((state_q == SSCEF_ST_SHIFT) & ~(m_trail & (cnt_q == 4'h0)) | start)
                            : ((cnt_q != 4'h0) | (lead & ~last));
      xmit_q   <= (start & is_i2c) | (xmit_q & ~done_q & is_i2c);
      o_sck    <= sck_q;
      o_sck_oe <= is_master;
      o_sdo    <= sdo_q;
      o_sdo_oe <= is_master | (is_slave & ss_ok) | (is_i2c & xmit_q & ~sdo_q);
    end
  end

  assign eng.busy     = busy_q;
  assign eng.done     = done_q;
  assign eng.rx_data  = rx_q;
  assign eng.i2c_xmit = xmit_q;

endmodule // sscef_shift_engine

// File: rtl/sscef_top.sv
// sync serial port: apb registers, receive buffer, collision and overflow flags
`timescale 1ns/100ps

module sscef_top
  import sscef_pkg::*;
#(
  parameter int unsigned DATA_W = SSCEF_DATA_W
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq,
  input  wire logic        i_sck,
  input  wire logic        i_sdi,
  input  wire logic        i_ss_n,
  output logic             o_sck,
  output logic             o_sck_oe,
  output logic             o_sdo,
  output logic             o_sdo_oe
);

  sscef_eng_if eng_if ();

  logic [7:0]             ctl_q;
  logic [7:0]             ctl_d;
  logic [DATA_W-1:0]      buf_q;
  logic [DATA_W-1:0]      buf_d;
  logic                   full_q;
  logic                   full_d;
  logic [SSCEF_IRQ_W-1:0] ist_q;
  logic [SSCEF_IRQ_W-1:0] ist_d;
  logic [SSCEF_IRQ_W-1:0] msk_q;
  logic [31:0]            prdata_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic                   irq_q;

  // apb decoding: answer comes in the first cycle of the access phase, with no wait states
  wire setup   = i_psel & ~i_penable & ~pready_q;
  wire access  = i_psel & i_penable & pready_q;
  wire wr      = access & i_pwrite;
  wire rd      = access & ~i_pwrite;
  wire hit_ist = i_paddr == SSCEF_ADDR_IRQ_STAT;
  wire hit_msk = i_paddr == SSCEF_ADDR_IRQ_MASK;
  wire hit_buf = i_paddr == SSCEF_ADDR_BUFFER;
  wire hit_sta = i_paddr == SSCEF_ADDR_STATUS;
  wire hit_ctl = i_paddr == SSCEF_ADDR_CONTROL;
  wire mapped  = hit_ist | hit_msk | hit_buf | hit_sta | hit_ctl;

  wire wr_ctl  = wr & hit_ctl;
  wire wr_buf  = wr & hit_buf;
  wire wr_ist  = wr & hit_ist;
  wire wr_msk  = wr & hit_msk;
  wire rd_buf  = rd & hit_buf;

  // mode decode
  wire [3:0] mode     = ctl_q[3:0];
  wire       enabled  = ctl_q[SSCEF_CTL_EN_BIT];
  wire       m_slave  = enabled & sscef_is_slave(mode);
  wire       m_i2c    = enabled & sscef_is_i2c(mode);

  // write collision: buffer written while a word is still shifting
  wire write_collision_flag_set = wr_buf & enabled & eng_if.busy;

  // receive path: a completed byte lands in the buffer or overflows; an i2c transmit byte does neither
  wire ovf_mode = m_slave | (m_i2c & ~eng_if.i2c_xmit);
  wire ovf_set  = eng_if.done & ovf_mode & full_q;
  wire rx_take  = eng_if.done & ~ovf_set & ~(m_i2c & eng_if.i2c_xmit);

  wire [SSCEF_IRQ_W-1:0] events = {write_collision_flag_set, ovf_set, rx_take};
  wire [SSCEF_IRQ_W-1:0] ist_clr = wr_ist ? i_pwdata[SSCEF_IRQ_W-1:0] : '0;

  wire [31:0] status_word = {30'h0, eng_if.busy, full_q};

  wire [31:0] rd_mux = hit_ctl ? {24'h0, ctl_q} :
                       hit_buf ? {{(32 - DATA_W){1'b0}}, buf_q} :
                       hit_sta ? status_word :
                       hit_ist ? {{(32 - SSCEF_IRQ_W){1'b0}}, ist_q} :
                       hit_msk ? {{(32 - SSCEF_IRQ_W){1'b0}}, msk_q} : 32'h0;

  // control register: writable bits, hardware-set flags win over a clear
  always_comb begin
    ctl_d = wr_ctl ? i_pwdata[7:0] : ctl_q;
    ctl_d[SSCEF_CTL_WRITE_COLLISION_FLAG_BIT] = ctl_d[SSCEF_CTL_WRITE_COLLISION_FLAG_BIT] | write_collision_flag_set;
    ctl_d[SSCEF_CTL_OVF_BIT] = ctl_d[SSCEF_CTL_OVF_BIT] | ovf_set;
  end

  // buffer holds the last accepted byte; full clears on read
  always_comb begin
    buf_d  = rx_take ? eng_if.rx_data : buf_q;
    full_d = rx_take | (full_q & ~rd_buf);
    ist_d  = (ist_q & ~ist_clr) | events;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ctl_q  <= SSCEF_CTL_RESET;
      buf_q  <= '0;
      full_q <= 1'b0;
    end else begin
      ctl_q  <= ctl_d;
      buf_q  <= buf_d;
      full_q <= full_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ist_q <= SSCEF_IRQ_RESET;
      msk_q <= SSCEF_IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      ist_q <= ist_d;
      if (wr_msk) begin
        msk_q <= i_pwdata[SSCEF_IRQ_W-1:0];
      end
      irq_q <= |(ist_d & (wr_msk ? i_pwdata[SSCEF_IRQ_W-1:0] : msk_q));
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= (setup & ~i_pwrite) ? rd_mux : 32'h0;
    end
  end

  // engine control
  assign eng_if.en      = enabled;
  assign eng_if.mode    = mode;
  assign eng_if.clock_polarity_select     = ctl_q[SSCEF_CTL_CKP_BIT];
  assign eng_if.load    = wr_buf & enabled & ~eng_if.busy;
  assign eng_if.tx_data = i_pwdata[DATA_W-1:0];

  sscef_shift_engine #(
    .DATA_W (DATA_W)
  ) u_engine (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .eng        (eng_if.eng),
    .i_sck      (i_sck),
    .i_sdi      (i_sdi),
    .i_ss_n     (i_ss_n),
    .o_sck      (o_sck),
    .o_sck_oe   (o_sck_oe),
    .o_sdo      (o_sdo),
    .o_sdo_oe   (o_sdo_oe)
  );

  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_irq     = irq_q;

endmodule // sscef_top

// File: sim/sscef_top_asserts.sv
// checker: apb handshake, control register read and irq reset properties
`timescale 1ns/100ps
module sscef_top_asserts (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] o_prdata,
  input  wire logic        o_pready,
  input  wire logic        o_pslverr,
  input  wire logic        o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  logic ctl_rd;
  assign ctl_rd = i_psel && i_penable && !i_pwrite && (i_paddr == 32'h0000_0014);
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
  a_ready_in_access: assert property (o_pready |-> i_psel && i_penable) else $error("ready outside access");
  a_error_data_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0) else $error("bad error answer");
  a_idle_data_zero: assert property (!o_pready |-> o_prdata == 32'h0) else $error("read data outside access");
  a_ctl_upper_zero: assert property (o_pready && ctl_rd |-> o_prdata[31:8] == 24'h0 && !o_pslverr)
    else $error("control read malformed");
  a_unmapped_error: assert property (o_pready && i_paddr == 32'h0000_0010 |-> o_pslverr) else $error("no error");
  a_irq_after_reset: assert property ($rose(i_resetn) |-> !o_irq) else $error("irq high after reset");
  c_ctl_read: cover property (o_pready && ctl_rd);
  c_error: cover property (o_pslverr);
  c_irq: cover property (o_irq);
endmodule // sscef_top_asserts

// File: sim/sscef_spi_partner.sv
// external serial master model: drives clock, data and select into the port
`timescale 1ns/100ps
module sscef_spi_partner (
  input  wire logic i_core_clk,
  input  wire logic i_sdo,
  output logic      o_sck,
  output logic      o_sdi,
  output logic      o_ss_n
);
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b1;
    o_ss_n = 1'b1;
  end
  // msb first, data set up before rising sck; sck stands still between frames
  // the port's reply is captured from i_sdo at each rising sck
  task automatic send(input logic [7:0] b, output logic [7:0] got);
    o_ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge i_core_clk);
      o_sdi <= b[i];
      repeat (4) @(posedge i_core_clk);
      o_sck <= 1'b1;
      got[i] = i_sdo;
      repeat (4) @(posedge i_core_clk);
      o_sck <= 1'b0;
    end
    repeat (4) @(posedge i_core_clk);
    o_ss_n <= 1'b1;
    o_sdi <= ~b[0];
  endtask
endmodule // sscef_spi_partner

// File: sim/sscef_top_bench.sv
// testbench: apb register tests, slave and i2c overflow, master collision
`timescale 1ns/100ps
module sscef_top_bench;
  import sscef_pkg::*;
  logic        core_clk, resetn, psel, penable, pwrite, irq, pready, perr_q, sck, sdi, ss_n;
  logic [31:0] paddr, pwdata, prdata, rdata;
  int          mismatches, total_checks;
  logic        msck, sck_oe, sdo, sdo_oe;
  logic        sck_prev = 1'b0;
  logic [7:0]  got;
  int          sck_rises = 0;
  int          rises0;
  sscef_top sscef_top_inst (.i_core_clk(core_clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(perr_q), .o_irq(irq), .i_sck(sck), .i_sdi(sdi), .i_ss_n(ss_n), .o_sck(msck), .o_sck_oe(sck_oe),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe));
  sscef_spi_partner sscef_spi_partner_inst (.i_core_clk(core_clk), .i_sdo(sdo), .o_sck(sck), .o_sdi(sdi),
    .o_ss_n(ss_n));
  logic perr;
  always #5 core_clk = ~core_clk;
  // counts rising edges of the master serial clock
  always @(posedge core_clk) begin
    sck_prev <= msck;
    if (msck === 1'b1 && sck_prev === 1'b0)
      sck_rises <= sck_rises + 1;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      test_done();
    end
    rdata = prdata;
    perr = perr_q;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, rdata);
  endtask
  task automatic wait_bit(input logic [31:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rdata[b] !== v && n < 200);
    if (n >= 200) begin
      mismatches++;
      test_done();
    end
  endtask
  initial begin
    core_clk = 1'b0; resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    mismatches = 0; total_checks = 0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk(SSCEF_ADDR_CONTROL, 32'h0, "ctl reset");
    wr(SSCEF_ADDR_CONTROL, 8'hdf);
    chk(SSCEF_ADDR_CONTROL, 32'hdf, "ctl rw a");
    wr(SSCEF_ADDR_CONTROL, 8'h25);
    chk(SSCEF_ADDR_CONTROL, 32'h25, "ctl rw b");
    wr(SSCEF_ADDR_BUFFER, 8'hc3);
    sscef_spi_partner_inst.send(8'ha5, got);
    cmp("slave tx", 32'hc3, {24'h0, got});
    cmp("slave sdo oe", 32'h1, {31'h0, sdo_oe});
    wait_bit(SSCEF_ADDR_STATUS, SSCEF_STAT_FULL_BIT, 1'b1);
    chk(SSCEF_ADDR_BUFFER, 32'ha5, "slave byte");
    sscef_spi_partner_inst.send(8'h3c, got);
    wait_bit(SSCEF_ADDR_STATUS, SSCEF_STAT_FULL_BIT, 1'b1);
    sscef_spi_partner_inst.send(8'h5a, got);
    wait_bit(SSCEF_ADDR_CONTROL, SSCEF_CTL_OVF_BIT, 1'b1);
    chk(SSCEF_ADDR_CONTROL, 32'h65, "slave ovf");
    chk(SSCEF_ADDR_BUFFER, 32'h3c, "kept byte");
    chk(SSCEF_ADDR_IRQ_STAT, 32'h3, "irq stat");
    wr(SSCEF_ADDR_IRQ_MASK, 8'h02);
    cmp("irq on", 32'h1, {31'h0, irq});
    wr(SSCEF_ADDR_IRQ_STAT, 8'h07);
    cmp("irq off", 32'h0, {31'h0, irq});
    wr(SSCEF_ADDR_CONTROL, 8'h26);
    sscef_spi_partner_inst.send(8'h81, got);
    wait_bit(SSCEF_ADDR_STATUS, SSCEF_STAT_FULL_BIT, 1'b1);
    sscef_spi_partner_inst.send(8'h42, got);
    wait_bit(SSCEF_ADDR_CONTROL, SSCEF_CTL_OVF_BIT, 1'b1);
    wr(SSCEF_ADDR_CONTROL, 8'h26);
    wr(SSCEF_ADDR_BUFFER, 8'h99);
    sscef_spi_partner_inst.send(8'h77, got);
    chk(SSCEF_ADDR_CONTROL, 32'h26, "i2c xmit no ovf");
    chk(SSCEF_ADDR_BUFFER, 32'h81, "i2c kept");
    wr(SSCEF_ADDR_CONTROL, 8'h20);
    rises0 = sck_rises;
    wr(SSCEF_ADDR_BUFFER, 8'h11);
    wr(SSCEF_ADDR_BUFFER, 8'h22);
    wait_bit(SSCEF_ADDR_STATUS, SSCEF_STAT_BUSY_BIT, 1'b0);
    chk(SSCEF_ADDR_CONTROL, 32'ha0, "collision");
    cmp("master sck oe", 32'h1, {31'h0, sck_oe});
    wr(SSCEF_ADDR_BUFFER, 8'h33);
    wait_bit(SSCEF_ADDR_STATUS, SSCEF_STAT_BUSY_BIT, 1'b0);
    chk(SSCEF_ADDR_CONTROL, 32'ha0, "master no ovf");
    cmp("master sck rises", 32'd16, sck_rises - rises0);
    chk(32'h0000_0010, 32'h0, "unmapped data");
    cmp("unmapped err", 32'h1, {31'h0, perr});
    test_done();
  end
endmodule // sscef_top_bench
bind sscef_top sscef_top_asserts sscef_top_asserts_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));
